// ---- logic/hwil_pkg.sv ----
package hwil_pkg;

  // Register word offsets on the host port
  localparam logic [15:0] HWIL_OFF_PENDING = 16'h0006;
  localparam logic [15:0] HWIL_OFF_ENABLE  = 16'h000f;
  localparam logic [15:0] HWIL_OFF_OUT_EN  = 16'h0013;

  // Field positions of the lower sources
  localparam int HWIL_BIT_LB_A    = 12;
  localparam int HWIL_BIT_LB_B    = 11;
  localparam int HWIL_BIT_TTM     = 7;
  localparam int HWIL_BIT_APF     = 3;
  localparam int HWIL_BIT_SUMMARY = 2;

  // Writable source bits and reset values
  localparam logic [15:0] HWIL_SRC_MASK    = 16'h1888;
  localparam logic [15:0] HWIL_PEND_RESET  = 16'h0008;
  localparam logic [15:0] HWIL_EN_RESET    = 16'h0000;
  localparam logic [15:0] HWIL_OUT_EN_RESET = 16'h0000;

  // Edges after reset release before the synchronised address is valid
  localparam logic [1:0] HWIL_CAPTURE_CNT = 2'h2;

  // Register access from the host port decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hwil_req_t;

  // Word handed to a bus encoder
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] data;
  } hwil_txw_t;

  // Word recovered by a bus decoder, with its check results
  typedef struct packed {
    logic        valid;
    logic        sync_ok;
    logic        manch_ok;
    logic        cnt_ok;
    logic        par_ok;
    logic [15:0] data;
  } hwil_rxw_t;

endpackage

// ---- logic/hwil_irq_low.sv ----
// Function
// - validate next decoded word after each transmit
// - compare loop-back data on last word
// - bus A loop failure sets bit 12
// - bus B loop failure sets bit 11
// - unused bits always read zero
// - time tag reaching match value sets bit 7
// - even address parity sets bit 3
// - enable registers bits 2-0 read zero
// - bit 2 shows terminal pending summary
// - reset: parity bit one, others zero
// - latch needs enable; pin needs output enable
`timescale 1ns/100ps
module hwil_irq_low (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  input  wire hwil_pkg::hwil_req_t i_req,
  input  wire hwil_pkg::hwil_txw_t i_tx_a,
  input  wire hwil_pkg::hwil_txw_t i_tx_b,
  input  wire hwil_pkg::hwil_rxw_t i_rx_a,
  input  wire hwil_pkg::hwil_rxw_t i_rx_b,
  input  wire logic               i_ttag_inc,
  input  wire logic [15:0]        i_ttag_value,
  input  wire logic [15:0]        i_ttag_match,
  input  wire logic [4:0]         i_rt_addr,
  input  wire logic               i_rt_addr_par,
  input  wire logic [15:0]        i_rt_pending,
  output logic [15:0]             o_reg_rdata,
  output logic                    o_irq
);
  import hwil_pkg::*;

  // Full word check done by the decoder
  function automatic logic word_ok(input hwil_rxw_t w);
    word_ok = w.sync_ok & w.manch_ok & w.cnt_ok & w.par_ok;
  endfunction

  hwil_txw_t   tx_w   [2];
  hwil_rxw_t   rx_w   [2];
  logic [1:0]  armed_q;
  logic [1:0]  last_q;
  logic [15:0] txd_q  [2];
  logic [1:0]  lb_evt_q;
  logic        ttm_evt_q;
  logic        apf_evt_q;
  logic [15:0] en_q;
  logic [15:0] oen_q;
  logic [15:0] pend_q;
  logic [15:0] pend_d;
  logic [15:0] evt;
  logic [15:0] clr;
  logic [4:0]  addr_s1_q;
  logic [4:0]  addr_s2_q;
  logic        par_s1_q;
  logic        par_s2_q;
  logic [1:0]  cap_cnt_q;

  assign tx_w[0] = i_tx_a;
  assign tx_w[1] = i_tx_b;
  assign rx_w[0] = i_rx_a;
  assign rx_w[1] = i_rx_b;

  // Loop-back checker per bus; index 0 is bus A, 1 is bus B
  for (genvar b = 0; b < 2; b++) begin : g_loop
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        armed_q[b]  <= 1'b0;
        last_q[b]   <= 1'b0;
        txd_q[b]    <= 16'h0000;
        lb_evt_q[b] <= 1'b0;
      end else begin
        lb_evt_q[b] <= 1'b0;
        if (tx_w[b].valid) begin
          armed_q[b] <= 1'b1;
          last_q[b]  <= tx_w[b].last;
          txd_q[b]   <= tx_w[b].data;
        end else if (armed_q[b] && rx_w[b].valid) begin
          // Only the word right after our own transmit is checked
          armed_q[b]  <= 1'b0;
          lb_evt_q[b] <= !word_ok(rx_w[b])
                         || (last_q[b] && (rx_w[b].data != txd_q[b]));
        end
      end
    end
  end

  // Time tag match seen on the increment that lands on the match value
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ttm_evt_q <= 1'b0;
    end else begin
      ttm_evt_q <= i_ttag_inc && (i_ttag_value == i_ttag_match);
    end
  end

  // Address straps are pins, so they are synchronised before use
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_s1_q <= 5'h00;
      addr_s2_q <= 5'h00;
      par_s1_q  <= 1'b0;
      par_s2_q  <= 1'b0;
    end else begin
      addr_s1_q <= i_rt_addr;
      addr_s2_q <= addr_s1_q;
      par_s1_q  <= i_rt_addr_par;
      par_s2_q  <= par_s1_q;
    end
  end

  // One-shot parity check once the synchroniser has filled after reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_cnt_q <= 2'h0;
      apf_evt_q <= 1'b0;
    end else begin
      apf_evt_q <= 1'b0;
      if (cap_cnt_q != 2'h3) begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
      end
      if (cap_cnt_q == HWIL_CAPTURE_CNT) begin
        apf_evt_q <= ~(^{addr_s2_q, par_s2_q});
      end
    end
  end

  // Source events placed at their register positions
  always_comb begin
    evt                   = 16'h0000;
    evt[HWIL_BIT_LB_A]    = lb_evt_q[0];
    evt[HWIL_BIT_LB_B]    = lb_evt_q[1];
    evt[HWIL_BIT_TTM]     = ttm_evt_q;
    evt[HWIL_BIT_APF]     = apf_evt_q;
  end

  // Write-one-to-clear; an event in the same cycle keeps the bit set
  always_comb begin
    clr    = (i_req.wr && i_req.addr == HWIL_OFF_PENDING) ? i_req.wdata : 16'h0000;
    pend_d = ((pend_q & ~clr) | (evt & en_q)) & HWIL_SRC_MASK;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= HWIL_PEND_RESET;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Enable and output-enable; bits outside the sources never store
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_q  <= HWIL_EN_RESET;
      oen_q <= HWIL_OUT_EN_RESET;
    end else if (i_req.wr) begin
      if (i_req.addr == HWIL_OFF_ENABLE) begin
        en_q <= i_req.wdata & HWIL_SRC_MASK;
      end
      if (i_req.addr == HWIL_OFF_OUT_EN) begin
        oen_q <= i_req.wdata & HWIL_SRC_MASK;
      end
    end
  end

  // Read data is registered; the summary is sampled live at the read
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        HWIL_OFF_PENDING: o_reg_rdata <= pend_q | {13'h0000, |i_rt_pending, 2'h0};
        HWIL_OFF_ENABLE:  o_reg_rdata <= en_q;
        HWIL_OFF_OUT_EN:  o_reg_rdata <= oen_q;
        default:          o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Pin follows pending gated by output-enable; summary has no pin path
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(pend_q & oen_q);
    end
  end

  // Helper marking the first edge after reset release
  logic seen_q;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_bad_a;
    armed_q[0] && !tx_w[0].valid && rx_w[0].valid && !word_ok(rx_w[0]);
  endsequence
  sequence s_mismatch_b;
    armed_q[1] && last_q[1] && !tx_w[1].valid && rx_w[1].valid
      && word_ok(rx_w[1]) && (rx_w[1].data != txd_q[1]);
  endsequence
  sequence s_lb_a_latch;
    lb_evt_q[0] && en_q[HWIL_BIT_LB_A];
  endsequence

  a_bad_word_a: assert property (s_bad_a |=> lb_evt_q[0])
    else $error("invalid loop-back word on bus A not flagged");
  a_mismatch_b: assert property (s_mismatch_b ##1 en_q[HWIL_BIT_LB_B] |=> pend_q[HWIL_BIT_LB_B])
    else $error("last word mismatch on bus B not latched");
  a_lb_a_pend: assert property (s_lb_a_latch |=> pend_q[HWIL_BIT_LB_A])
    else $error("bus A loop failure not pending");
  a_lb_b_pend: assert property (lb_evt_q[1] && en_q[HWIL_BIT_LB_B] |=> pend_q[HWIL_BIT_LB_B])
    else $error("bus B loop failure not pending");
  a_reserved_zero: assert property ((pend_q & ~HWIL_SRC_MASK) == 16'h0000)
    else $error("reserved pending bit set");
  a_ttm_event: assert property (i_ttag_inc && i_ttag_value == i_ttag_match
                                ##1 en_q[HWIL_BIT_TTM] |=> pend_q[HWIL_BIT_TTM])
    else $error("time tag match not pending");
  a_apf_event: assert property (cap_cnt_q == HWIL_CAPTURE_CNT && !(^{addr_s2_q, par_s2_q})
                                |=> apf_evt_q)
    else $error("address parity failure missed");
  a_enable_low: assert property (en_q[2:0] == 3'h0 && oen_q[2:0] == 3'h0)
    else $error("enable low bits not zero");
  a_summary_read: assert property (i_req.rd && i_req.addr == HWIL_OFF_PENDING
                                   |=> o_reg_rdata[HWIL_BIT_SUMMARY]
                                       == ($past(i_rt_pending) != 16'h0000))
    else $error("summary bit does not follow terminal pending");
  a_reset_value: assert property (!seen_q |-> pend_q[HWIL_BIT_APF] && !pend_q[HWIL_BIT_LB_A]
                                  && !pend_q[HWIL_BIT_LB_B] && !pend_q[HWIL_BIT_TTM])
    else $error("pending reset value wrong");
  a_gate_enable: assert property (!pend_q[HWIL_BIT_TTM] && !(ttm_evt_q && en_q[HWIL_BIT_TTM])
                                  |=> !pend_q[HWIL_BIT_TTM])
    else $error("source latched without enable");
  a_irq_gate: assert property (##1 o_irq == |($past(pend_q) & $past(oen_q)))
    else $error("interrupt pin not gated by output enable");
  a_hold_set: assert property (pend_q[HWIL_BIT_LB_A] && !(i_req.wr && i_req.addr == HWIL_OFF_PENDING
                               && i_req.wdata[HWIL_BIT_LB_A]) |=> pend_q[HWIL_BIT_LB_A])
    else $error("pending bit lost without clear");

endmodule // hwil_irq_low

// ---- tb/hwil_host_model.sv ----
`timescale 1ns/100ps
// Host side of the serial port, seen after the port decoder
module hwil_host_model (
  input  wire logic           i_mclk,
  output hwil_pkg::hwil_req_t o_req
);
  import hwil_pkg::*;

  initial o_req = '0;

  // One access per call; address and data are scrambled once released
  task automatic reg_access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    @(posedge i_mclk);
    o_req <= '{wr, !wr, addr, data};
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b0, ~addr, ~data};
  endtask
endmodule // hwil_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import hwil_pkg::*;
  logic        i_mclk;
  logic        i_rst_b;
  hwil_req_t   req;
  hwil_txw_t   tx_a, tx_b;
  hwil_rxw_t   rx_a, rx_b;
  logic        ttag_inc, irq, rd_d1, rt_par;
  logic [4:0]  rt_addr;
  logic [15:0] ttag_val, ttag_match, rt_pend, rdata;
  logic [15:0] exp_q[$];
  int          n_errors, compares, seed;

  hwil_irq_low u_hwil_irq_low (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req),
    .i_tx_a(tx_a), .i_tx_b(tx_b), .i_rx_a(rx_a), .i_rx_b(rx_b), .i_ttag_inc(ttag_inc),
    .i_ttag_value(ttag_val), .i_ttag_match(ttag_match), .i_rt_addr(rt_addr),
    .i_rt_addr_par(rt_par), .i_rt_pending(rt_pend), .o_reg_rdata(rdata), .o_irq(irq));
  hwil_host_model u_hwil_host_model (.i_mclk(i_mclk), .o_req(req));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Read data lands one cycle after the request is taken
  always @(posedge i_mclk) rd_d1 <= req.rd;
  always @(negedge i_mclk) begin
    if (rd_d1) begin
      compares++;
      if (exp_q.size() == 0 || rdata !== exp_q[0]) fail("read data differs");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_hwil_host_model.reg_access(1'b0, a, 16'h0000);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_hwil_host_model.reg_access(1'b1, a, d);
  endtask

  task automatic chk_irq(input logic e);
    compares++;
    if (irq !== e) fail("interrupt level differs");
  endtask

  // Transmit a word, then let the decoder report one: k 0-3 drops a flag,
  // k 4 is a last word with wrong data, k 5 is a clean last word,
  // k 6 is a wrong word that is not last and so must pass
  task automatic lb(input int bus, input int k);
    logic [15:0] d;
    hwil_rxw_t   r;
    d = 16'($random(seed));
    r = '{1'b1, k != 0, k != 1, k != 2, k != 3, (k == 4 || k == 6) ? ~d : d};
    @(posedge i_mclk);
    if (bus == 0) tx_a <= '{1'b1, k == 4 || k == 5, d};
    else tx_b <= '{1'b1, k == 4 || k == 5, d};
    @(posedge i_mclk);
    tx_a.valid <= 1'b0;
    tx_b.valid <= 1'b0;
    @(posedge i_mclk);
    if (bus == 0) rx_a <= r;
    else rx_b <= r;
    @(posedge i_mclk);
    rx_a.valid <= 1'b0;
    rx_b.valid <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask

  task automatic clear_all;
    wr(HWIL_OFF_PENDING, 16'hffff);
    @(posedge i_mclk);
    #1;
    chk_irq(1'b0);
  endtask

  initial begin
    seed = 32'h27fb;
    i_rst_b = 1'b0;
    {tx_a, tx_b, rx_a, rx_b, ttag_inc, ttag_val, ttag_match, rt_pend} = '0;
    rt_addr = 5'h01;
    rt_par = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(HWIL_OFF_PENDING, 16'h0008);
    rd(HWIL_OFF_ENABLE, 16'h0000);
    rd(16'h0040, 16'h0000);
    wr(HWIL_OFF_ENABLE, 16'hffff);
    wr(HWIL_OFF_OUT_EN, 16'hffff);
    rd(HWIL_OFF_ENABLE, 16'h1888);
    rd(HWIL_OFF_OUT_EN, 16'h1888);
    clear_all();
    rd(HWIL_OFF_PENDING, 16'h0000);
    $display("test registers done");
    // Every failing flag, a data mismatch and a clean word on both buses
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 7; k++) begin
        lb(b, k);
        chk_irq(k < 5);
        rd(HWIL_OFF_PENDING, (k >= 5) ? 16'h0000 : (b == 0) ? 16'h1000 : 16'h0800);
        clear_all();
      end
    end
    $display("test loop-back done");
    @(posedge i_mclk);
    ttag_match <= 16'($random(seed));
    @(posedge i_mclk);
    ttag_inc <= 1'b1;
    ttag_val <= ttag_match;
    @(posedge i_mclk);
    ttag_val <= ttag_match + 16'h0001;
    repeat (3) @(posedge i_mclk);
    ttag_inc <= 1'b0;
    rd(HWIL_OFF_PENDING, 16'h0080);
    clear_all();
    @(posedge i_mclk);
    rt_pend <= 16'($random(seed)) | 16'h0001;
    repeat (2) @(posedge i_mclk);
    rd(HWIL_OFF_PENDING, 16'h0004);
    rt_pend <= 16'h0000;
    // Host follows the summary to the terminal register, which lives elsewhere
    rd(16'h0009, 16'h0000);
    rd(HWIL_OFF_PENDING, 16'h0000);
    chk_irq(1'b0);
    $display("test time tag and summary done");
    // Gating: no pin without output enable, no latch without enable
    wr(HWIL_OFF_OUT_EN, 16'h0000);
    wr(HWIL_OFF_ENABLE, 16'h1000);
    lb(0, 0);
    lb(1, 2);
    lb(0, 1);
    chk_irq(1'b0);
    rd(HWIL_OFF_PENDING, 16'h1000);
    $display("test gating done");
    // Mid-run reset with even strap parity; the clear lands before the
    // one-shot check, so bit 3 only comes back if the check fires
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    rt_addr <= 5'h03;
    repeat (2) @(posedge i_mclk);
    #1;
    chk_irq(1'b0);
    fork
      begin
        @(posedge i_mclk);
        i_rst_b <= 1'b1;
      end
      wr(HWIL_OFF_ENABLE, 16'h0008);
    join
    wr(HWIL_OFF_PENDING, 16'h0008);
    rd(HWIL_OFF_PENDING, 16'h0008);
    rd(HWIL_OFF_OUT_EN, 16'h0000);
    $display("test reset done");
    repeat (4) @(posedge i_mclk);
    report_and_stop();
  end

  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
endmodule // tb_top
